/* File: core/uart_a_pins_strap_capture.sv */
// Purpose: Channel A pin levels, simple transmitter, infrared path, strap capture
// Assumes: REF_CLK 25 MHz, SRST synchronous active high, held at least 4 cycles
// Notes: Strap pins are released during reset so the pull-up or strap sets the level
`timescale 1ns/10ps
`default_nettype none
module uart_a_pins_strap_capture #(
   parameter int DATA_BITS = uart_a_pins_pkg::DATA_BITS_DFLT
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic CLK_SEL_48,
   input wire logic [15:0] DIVISOR,
   input wire logic IR_MODE,
   input wire logic TX_START,
   input wire logic [7:0] TX_DATA,
   output logic TX_BUSY,
   input wire logic CHAN_A_SERIAL_IN,
   input wire logic INFRARED_RX_IN,
   output logic RX_LINE,
   output logic RX_START,
   input wire logic CHAN_A_SET_READY_N,
   input wire logic CHAN_A_RING_N,
   input wire logic CHAN_A_CARRIER_N,
   input wire logic MODEM_GPI_MODE,
   output logic [2:0] MODEM_STATUS,
   input wire logic MODEM_GPO_MODE,
   input wire logic RTS_ASSERT,
   input wire logic DTR_ASSERT,
   input wire logic GPO_RTS,
   input wire logic GPO_DTR,
   input wire logic WDT_EXPIRED,
   input wire logic CHAN_A_SERIAL_OUT_I,
   output logic CHAN_A_SERIAL_OUT_O,
   output logic CHAN_A_SERIAL_OUT_OE,
   input wire logic CHAN_A_TERMINAL_READY_N_I,
   output logic CHAN_A_TERMINAL_READY_N_O,
   output logic CHAN_A_TERMINAL_READY_N_OE,
   input wire logic CHAN_A_SEND_REQUEST_N_I,
   output logic CHAN_A_SEND_REQUEST_N_O,
   output logic CHAN_A_SEND_REQUEST_N_OE,
   input wire logic WATCHDOG_EXPIRY_N_I,
   output logic WATCHDOG_EXPIRY_N_O,
   output logic WATCHDOG_EXPIRY_N_OE,
   output logic INFRARED_TX_OUT,
   input wire uart_a_pins_pkg::cfg_wr_s CFG_WR,
   output uart_a_pins_pkg::ldev_cfg_s CHAN_A_CFG,
   output uart_a_pins_pkg::ldev_cfg_s WDT_CFG,
   output uart_a_pins_pkg::strap_s STRAPS,
   output logic [7:0] CFG_INDEX_PORT,
   output logic [7:0] CFG_DATA_PORT
);
   if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_chk
      $error("DATA_BITS must be 5 to 8");
   end

   localparam logic [3:0] SUB_LAST = 4'(uart_a_pins_pkg::OVERSAMPLE - 1);
   localparam logic [3:0] IR_TICKS = 4'(uart_a_pins_pkg::IR_PULSE_TICKS);
   localparam logic [4:0] PRE_LAST_24 = 5'(uart_a_pins_pkg::PRESCALE_24 - 1);
   localparam logic [4:0] PRE_LAST_48 = 5'(uart_a_pins_pkg::PRESCALE_48 - 1);
   localparam logic [2:0] BIT_LAST = 3'(DATA_BITS - 1);

   logic [uart_a_pins_pkg::SYNC_W-1:0] pin_in;
   logic [uart_a_pins_pkg::SYNC_W-1:0] s1_q;
   logic [uart_a_pins_pkg::SYNC_W-1:0] s2_q;
   uart_a_pins_pkg::strap_s strap_live;
   uart_a_pins_pkg::tx_state_e state_q;
   logic [4:0] pre_q;
   logic [15:0] div_q;
   logic [4:0] pre_last;
   logic [15:0] div_last;
   logic tick_q;
   logic [3:0] sub_q;
   logic [2:0] bit_q;
   logic [7:0] shift_q;
   logic line_q;
   logic rx_now;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   assign pin_in = {WATCHDOG_EXPIRY_N_I, CHAN_A_SEND_REQUEST_N_I, CHAN_A_TERMINAL_READY_N_I,
                    CHAN_A_SERIAL_OUT_I, CHAN_A_CARRIER_N, CHAN_A_RING_N, CHAN_A_SET_READY_N,
                    INFRARED_RX_IN, CHAN_A_SERIAL_IN};

   for (genvar i = 0; i < uart_a_pins_pkg::SYNC_W; i++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
         s1_q[i] <= pin_in[i];
         s2_q[i] <= s1_q[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture
   assign strap_live = '{s2_q[uart_a_pins_pkg::SYN_RTS], s2_q[uart_a_pins_pkg::SYN_DTR],
                         s2_q[uart_a_pins_pkg::SYN_TX], s2_q[uart_a_pins_pkg::SYN_WDT]};

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         STRAPS <= strap_live;
      end
   end

   always_ff @(posedge REF_CLK) begin
      CFG_INDEX_PORT <= STRAPS.cfg_port ? uart_a_pins_pkg::CFG_INDEX_STRAP_HI
                                        : uart_a_pins_pkg::CFG_INDEX_STRAP_LO;
      CFG_DATA_PORT <= STRAPS.cfg_port ? uart_a_pins_pkg::CFG_DATA_STRAP_HI
                                       : uart_a_pins_pkg::CFG_DATA_STRAP_LO;
   end

   strap_cfg_reg #(.DEV(uart_a_pins_pkg::DEV_CHAN_A)) u_cfg_a (
      .clk(REF_CLK),
      .srst(SRST),
      .dflt(uart_a_pins_pkg::strap_default(uart_a_pins_pkg::DEV_CHAN_A, strap_live)),
      .wr(CFG_WR),
      .cfg_q(CHAN_A_CFG)
   );

   strap_cfg_reg #(.DEV(uart_a_pins_pkg::DEV_WDT)) u_cfg_wdt (
      .clk(REF_CLK),
      .srst(SRST),
      .dflt(uart_a_pins_pkg::strap_default(uart_a_pins_pkg::DEV_WDT, strap_live)),
      .wr(CFG_WR),
      .cfg_q(WDT_CFG)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Oversample tick
   assign pre_last = CLK_SEL_48 ? PRE_LAST_48 : PRE_LAST_24;
   assign div_last = (DIVISOR == 16'h0000) ? 16'h0000 : DIVISOR - 16'h0001;

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         pre_q <= 5'h00;
         div_q <= 16'h0000;
         tick_q <= 1'h0;
      end else begin
         tick_q <= 1'h0;
         if (pre_q >= pre_last) begin
            pre_q <= 5'h00;
            if (div_q >= div_last) begin
               div_q <= 16'h0000;
               tick_q <= 1'h1;
            end else begin
               div_q <= div_q + 16'h0001;
            end
         end else begin
            pre_q <= pre_q + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state_q <= uart_a_pins_pkg::TX_IDLE;
         sub_q <= 4'h0;
         bit_q <= 3'h0;
         shift_q <= 8'h00;
         line_q <= 1'h1;
         TX_BUSY <= 1'h0;
      end else begin
         unique case (state_q)
            uart_a_pins_pkg::TX_IDLE: begin
               line_q <= 1'h1;
               if (TX_START) begin
                  state_q <= uart_a_pins_pkg::TX_START_BIT;
                  shift_q <= TX_DATA;
                  line_q <= 1'h0;
                  sub_q <= 4'h0;
                  bit_q <= 3'h0;
                  TX_BUSY <= 1'h1;
               end
            end
            uart_a_pins_pkg::TX_START_BIT, uart_a_pins_pkg::TX_DATA_BIT, uart_a_pins_pkg::TX_STOP_BIT: begin
               if (tick_q) begin
                  sub_q <= sub_q + 4'h1;
                  if (sub_q == SUB_LAST) begin
                     if (state_q == uart_a_pins_pkg::TX_STOP_BIT) begin
                        state_q <= uart_a_pins_pkg::TX_IDLE;
                        TX_BUSY <= 1'h0;
                     end else if (state_q == uart_a_pins_pkg::TX_DATA_BIT && bit_q == BIT_LAST) begin
                        state_q <= uart_a_pins_pkg::TX_STOP_BIT;
                        line_q <= 1'h1;
                     end else begin
                        if (state_q == uart_a_pins_pkg::TX_DATA_BIT) begin
                           bit_q <= bit_q + 3'h1;
                        end
                        state_q <= uart_a_pins_pkg::TX_DATA_BIT;
                        line_q <= shift_q[0];
                        shift_q <= {1'h0, shift_q[7:1]};
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         CHAN_A_SERIAL_OUT_O <= 1'h1;
         INFRARED_TX_OUT <= 1'h0;
      end else begin
         CHAN_A_SERIAL_OUT_O <= IR_MODE | line_q;
         INFRARED_TX_OUT <= IR_MODE && !line_q && (sub_q < IR_TICKS) &&
                            (state_q == uart_a_pins_pkg::TX_START_BIT ||
                             state_q == uart_a_pins_pkg::TX_DATA_BIT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive line and modem inputs
   assign rx_now = IR_MODE ? !s2_q[uart_a_pins_pkg::SYN_IR] : s2_q[uart_a_pins_pkg::SYN_RX];

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         RX_LINE <= 1'h1;
         RX_START <= 1'h0;
         MODEM_STATUS <= 3'h0;
      end else begin
         RX_LINE <= rx_now;
         RX_START <= RX_LINE && !rx_now;
         MODEM_STATUS <= MODEM_GPI_MODE ?
            {s2_q[uart_a_pins_pkg::SYN_DSR], s2_q[uart_a_pins_pkg::SYN_RI], s2_q[uart_a_pins_pkg::SYN_CD]} :
            ~{s2_q[uart_a_pins_pkg::SYN_DSR], s2_q[uart_a_pins_pkg::SYN_RI], s2_q[uart_a_pins_pkg::SYN_CD]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output enables and modem outputs
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         CHAN_A_SERIAL_OUT_OE <= 1'h0;
         CHAN_A_TERMINAL_READY_N_O <= 1'h1;
         CHAN_A_TERMINAL_READY_N_OE <= 1'h0;
         CHAN_A_SEND_REQUEST_N_O <= 1'h1;
         CHAN_A_SEND_REQUEST_N_OE <= 1'h0;
         WATCHDOG_EXPIRY_N_O <= 1'h0;
         WATCHDOG_EXPIRY_N_OE <= 1'h0;
      end else begin
         CHAN_A_SERIAL_OUT_OE <= 1'h1;
         CHAN_A_TERMINAL_READY_N_O <= MODEM_GPO_MODE ? GPO_DTR : !DTR_ASSERT;
         CHAN_A_TERMINAL_READY_N_OE <= 1'h1;
         CHAN_A_SEND_REQUEST_N_O <= MODEM_GPO_MODE ? GPO_RTS : !RTS_ASSERT;
         CHAN_A_SEND_REQUEST_N_OE <= 1'h1;
         WATCHDOG_EXPIRY_N_OE <= WDT_EXPIRED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_tx_reset_high: assert property (@(posedge REF_CLK) SRST |=> CHAN_A_SERIAL_OUT_O)
      else $error("serial out not high after reset cycle");
   a_tx_idle_high: assert property (@(posedge REF_CLK) disable iff (SRST)
      (state_q == uart_a_pins_pkg::TX_IDLE && $past(state_q == uart_a_pins_pkg::TX_IDLE)) |=> CHAN_A_SERIAL_OUT_O)
      else $error("serial out low while idle");
   a_ir_idle_low: assert property (@(posedge REF_CLK)
      (SRST || state_q == uart_a_pins_pkg::TX_IDLE) |=> !INFRARED_TX_OUT)
      else $error("infrared out high while idle");
   a_ir_rx_detect: assert property (@(posedge REF_CLK) disable iff (SRST)
      (IR_MODE && s2_q[uart_a_pins_pkg::SYN_IR]) |=> !RX_LINE)
      else $error("infrared pulse not seen as data");
   a_strap_sample: assert property (@(posedge REF_CLK) SRST [*4] |=> (STRAPS == $past(strap_live)))
      else $error("strap not sampled in reset");
   a_rts_active_low: assert property (@(posedge REF_CLK) disable iff (SRST)
      (!MODEM_GPO_MODE && RTS_ASSERT) |=> (CHAN_A_SEND_REQUEST_N_OE && !CHAN_A_SEND_REQUEST_N_O))
      else $error("request to send not driven low");
   a_modem_low: assert property (@(posedge REF_CLK) disable iff (SRST)
      (!MODEM_GPI_MODE && !s2_q[uart_a_pins_pkg::SYN_DSR]) |=> MODEM_STATUS[2])
      else $error("set ready not active low");
   a_wdt_drain: assert property (@(posedge REF_CLK) disable iff (SRST)
      ##1 (!WATCHDOG_EXPIRY_N_O && (WATCHDOG_EXPIRY_N_OE == $past(WDT_EXPIRED))))
      else $error("watchdog output not open drain");
   a_baud_24: assert property (@(posedge REF_CLK) disable iff (SRST)
      (!CLK_SEL_48 && pre_q == PRE_LAST_24) |=> (pre_q == 5'h00))
      else $error("prescale wrong for 24 MHz");
   a_sw_write: assert property (@(posedge REF_CLK) disable iff (SRST)
      (CFG_WR.we && CFG_WR.dev == uart_a_pins_pkg::DEV_CHAN_A && CFG_WR.field == uart_a_pins_pkg::FLD_ENABLE)
      |=> (CHAN_A_CFG.enable == $past(CFG_WR.data)))
      else $error("software write lost");
   a_cfg_default: assert property (@(posedge REF_CLK)
      SRST [*4] |=> (CHAN_A_CFG == uart_a_pins_pkg::strap_default(uart_a_pins_pkg::DEV_CHAN_A, $past(strap_live))))
      else $error("channel defaults not from straps");
   a_cfg_port: assert property (@(posedge REF_CLK) disable iff (SRST)
      $past(!SRST) |-> (CFG_INDEX_PORT == (STRAPS.cfg_port ? uart_a_pins_pkg::CFG_INDEX_STRAP_HI
                                                         : uart_a_pins_pkg::CFG_INDEX_STRAP_LO)))
      else $error("config port pair wrong");
   a_strap_hold: assert property (@(posedge REF_CLK) disable iff (SRST) $past(!SRST) |-> $stable(STRAPS))
      else $error("strap changed after reset");

   c_tx_frame: cover property (@(posedge REF_CLK) disable iff (SRST) $fell(TX_BUSY));
   c_ir_pulse: cover property (@(posedge REF_CLK) disable iff (SRST) $rose(INFRARED_TX_OUT));
   c_port_low: cover property (@(posedge REF_CLK) disable iff (SRST) !STRAPS.cfg_port);
   c_wdt_fire: cover property (@(posedge REF_CLK) disable iff (SRST) $rose(WATCHDOG_EXPIRY_N_OE));
endmodule
`default_nettype wire

/* File: common/uart_a_pins_pkg.sv */
// Purpose: Shared constants and types for the channel A pin and strap block
// Assumes: Strap pins are sampled while SRST is high
// Notes: Default register values per strap level
//
// Functional notes
// - Serial transmit output sits high in reset and while no character is sent.
// - Infrared transmit output sits low in reset and while idle.
// - Infrared receive idles low; a high departure marks incoming data.
// - Terminal-ready and transmit pins are sampled in reset to seed channel A defaults.
// - Request-to-send drives active low or as a general output; sampled in reset.
// - Set-ready, ring and carrier inputs are active low or general inputs.
// - Watchdog expiry pulls its open-drain output low, else released.
// - Baud timing comes from a 24 MHz or 48 MHz reference clock.
// - Strap values load config registers in reset; software may overwrite later.
// - Strap pins set enable, base and interrupt defaults for channel and watchdog.
// - Request-to-send strap picks the config index and data port pair.
package uart_a_pins_pkg;
   localparam logic [7:0] VAL_OFF = 8'h00;
   localparam logic [7:0] ENABLE_ON = 8'h01;
   localparam logic [7:0] CHAN_A_BASE_HI = 8'h03;
   localparam logic [7:0] CHAN_A_BASE_LO_LOW = 8'hE0;
   localparam logic [7:0] CHAN_A_BASE_LO_HIGH = 8'hF8;
   localparam logic [7:0] CHAN_A_IRQ = 8'h03;
   localparam logic [7:0] WDT_BASE_HI = 8'h04;
   localparam logic [7:0] WDT_BASE_LO = 8'h42;
   localparam logic [7:0] WDT_IRQ = 8'h00;
   localparam logic [7:0] CFG_INDEX_STRAP_HI = 8'h2E;
   localparam logic [7:0] CFG_INDEX_STRAP_LO = 8'h4E;
   localparam logic [7:0] CFG_DATA_STRAP_HI = 8'h2F;
   localparam logic [7:0] CFG_DATA_STRAP_LO = 8'h4F;
   localparam logic DEV_CHAN_A = 1'h0;
   localparam logic DEV_WDT = 1'h1;
   localparam int PRESCALE_24 = 13;
   localparam int PRESCALE_48 = 26;
   localparam int OVERSAMPLE = 16;
   localparam int IR_PULSE_TICKS = 3;
   localparam int DATA_BITS_DFLT = 8;
   localparam int SYN_RX = 0;
   localparam int SYN_IR = 1;
   localparam int SYN_DSR = 2;
   localparam int SYN_RI = 3;
   localparam int SYN_CD = 4;
   localparam int SYN_TX = 5;
   localparam int SYN_DTR = 6;
   localparam int SYN_RTS = 7;
   localparam int SYN_WDT = 8;
   localparam int SYNC_W = 9;

   typedef enum logic [1:0] {TX_IDLE, TX_START_BIT, TX_DATA_BIT, TX_STOP_BIT} tx_state_e;
   typedef enum logic [1:0] {FLD_ENABLE, FLD_BASE_HI, FLD_BASE_LO, FLD_IRQSEL} cfg_field_e;

   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] base_hi;
      logic [7:0] base_lo;
      logic [7:0] irqsel;
   } ldev_cfg_s;

   typedef struct packed {
      logic cfg_port;
      logic a_low;
      logic a_high;
      logic wdt;
   } strap_s;

   typedef struct packed {
      logic we;
      logic dev;
      cfg_field_e field;
      logic [7:0] data;
   } cfg_wr_s;

   // Default register set selected by strap levels
   function automatic ldev_cfg_s strap_default(input logic dev, input strap_s s);
      ldev_cfg_s c;
      c = '{VAL_OFF, VAL_OFF, VAL_OFF, VAL_OFF};
      if (dev == DEV_WDT) begin
         if (s.wdt) begin
            c = '{ENABLE_ON, WDT_BASE_HI, WDT_BASE_LO, WDT_IRQ};
         end
      end else if (s.a_high) begin
         c = '{ENABLE_ON, CHAN_A_BASE_HI, CHAN_A_BASE_LO_HIGH, CHAN_A_IRQ};
      end else if (s.a_low) begin
         c = '{ENABLE_ON, CHAN_A_BASE_HI, CHAN_A_BASE_LO_LOW, CHAN_A_IRQ};
      end
      return c;
   endfunction
endpackage

/* File: core/strap_cfg_reg.sv */
// Purpose: One logical device's strap-seeded configuration registers
// Assumes: srst synchronous, active high
// Notes: Writes are ignored while srst is high
`timescale 1ns/10ps
`default_nettype none
module strap_cfg_reg #(
   parameter logic DEV = 1'h0
) (
   input wire logic clk,
   input wire logic srst,
   input wire uart_a_pins_pkg::ldev_cfg_s dflt,
   input wire uart_a_pins_pkg::cfg_wr_s wr,
   output uart_a_pins_pkg::ldev_cfg_s cfg_q
);
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_q <= dflt;
      end else if (wr.we && (wr.dev == DEV)) begin
         unique case (wr.field)
            uart_a_pins_pkg::FLD_ENABLE: cfg_q.enable <= wr.data;
            uart_a_pins_pkg::FLD_BASE_HI: cfg_q.base_hi <= wr.data;
            uart_a_pins_pkg::FLD_BASE_LO: cfg_q.base_lo <= wr.data;
            uart_a_pins_pkg::FLD_IRQSEL: cfg_q.irqsel <= wr.data;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: dv/line_xcvr_model.sv */
// Purpose: Line and infrared transceiver with strap resistors on the shared pins
// Assumes: Bench chooses strap levels and the level sent toward the block
// Notes: A released pin falls back to its strap or pull-up level
`timescale 1ns/10ps
`default_nettype none
module line_xcvr_model (
   input wire logic line_active,
   input wire logic line_bit,
   input wire logic [3:0] strap_lvl,
   input wire logic tx_o,
   input wire logic tx_oe,
   input wire logic dtr_o,
   input wire logic dtr_oe,
   input wire logic rts_o,
   input wire logic rts_oe,
   input wire logic wdt_o,
   input wire logic wdt_oe,
   output logic serial_in,
   output logic ir_in,
   output logic tx_pin,
   output logic dtr_pin,
   output logic rts_pin,
   output logic wdt_pin
);
   // Serial line idles high, infrared line idles low
   assign serial_in = line_active ? line_bit : 1'h1;
   assign ir_in = line_active ? ~line_bit : 1'h0;
   // Strap order {send request, terminal ready, transmit, watchdog}
   assign rts_pin = rts_oe ? rts_o : strap_lvl[3];
   assign dtr_pin = dtr_oe ? dtr_o : strap_lvl[2];
   assign tx_pin = tx_oe ? tx_o : strap_lvl[1];
   assign wdt_pin = wdt_oe ? wdt_o : strap_lvl[0];
endmodule
`default_nettype wire

/* File: dv/test_uart_a_pins_strap_capture.sv */
// Purpose: Self-checking bench for channel A pins and strap capture
// Assumes: 25 MHz clock, divisor 0 to 2, prescale 13 or 26
// Notes: Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/10ps
`default_nettype none
module test_uart_a_pins_strap_capture;
   logic ref_clk = 1'h0;
   logic srst = 1'h1;
   logic clk_sel_48 = 1'h0;
   logic [15:0] divisor = 16'h0001;
   logic ir_mode = 1'h0;
   logic tx_start = 1'h0;
   logic [7:0] tx_data = 8'h00;
   logic [2:0] modem_n = 3'h7;
   logic gpi_mode = 1'h0;
   logic gpo_mode = 1'h0;
   logic rts_assert = 1'h0;
   logic dtr_assert = 1'h0;
   logic gpo_rts = 1'h0;
   logic gpo_dtr = 1'h0;
   logic wdt_expired = 1'h0;
   logic line_active = 1'h0;
   logic line_bit = 1'h1;
   logic [3:0] straps = 4'hF;
   uart_a_pins_pkg::cfg_wr_s cfg_wr = '0;
   logic tx_busy, rx_line, rx_start, serial_in, ir_in, ir_tx;
   logic [2:0] modem_status;
   logic tx_o, tx_oe, tx_pin, dtr_o, dtr_oe, dtr_pin, rts_o, rts_oe, rts_pin, wdt_o, wdt_oe, wdt_pin;
   uart_a_pins_pkg::ldev_cfg_s chan_cfg;
   uart_a_pins_pkg::ldev_cfg_s wdt_cfg;
   uart_a_pins_pkg::strap_s strap_q;
   logic [7:0] idx_port, data_port;
   int err_count = 0;
   int num_checks = 0;

   uart_a_pins_strap_capture uart_a_pins_strap_capture_inst (.REF_CLK(ref_clk), .SRST(srst),
      .CLK_SEL_48(clk_sel_48), .DIVISOR(divisor), .IR_MODE(ir_mode), .TX_START(tx_start),
      .TX_DATA(tx_data), .TX_BUSY(tx_busy), .CHAN_A_SERIAL_IN(serial_in), .INFRARED_RX_IN(ir_in),
      .RX_LINE(rx_line), .RX_START(rx_start), .CHAN_A_SET_READY_N(modem_n[2]),
      .CHAN_A_RING_N(modem_n[1]), .CHAN_A_CARRIER_N(modem_n[0]), .MODEM_GPI_MODE(gpi_mode),
      .MODEM_STATUS(modem_status), .MODEM_GPO_MODE(gpo_mode), .RTS_ASSERT(rts_assert),
      .DTR_ASSERT(dtr_assert), .GPO_RTS(gpo_rts), .GPO_DTR(gpo_dtr), .WDT_EXPIRED(wdt_expired),
      .CHAN_A_SERIAL_OUT_I(tx_pin), .CHAN_A_SERIAL_OUT_O(tx_o), .CHAN_A_SERIAL_OUT_OE(tx_oe),
      .CHAN_A_TERMINAL_READY_N_I(dtr_pin), .CHAN_A_TERMINAL_READY_N_O(dtr_o),
      .CHAN_A_TERMINAL_READY_N_OE(dtr_oe), .CHAN_A_SEND_REQUEST_N_I(rts_pin),
      .CHAN_A_SEND_REQUEST_N_O(rts_o), .CHAN_A_SEND_REQUEST_N_OE(rts_oe),
      .WATCHDOG_EXPIRY_N_I(wdt_pin), .WATCHDOG_EXPIRY_N_O(wdt_o), .WATCHDOG_EXPIRY_N_OE(wdt_oe),
      .INFRARED_TX_OUT(ir_tx), .CFG_WR(cfg_wr), .CHAN_A_CFG(chan_cfg), .WDT_CFG(wdt_cfg),
      .STRAPS(strap_q), .CFG_INDEX_PORT(idx_port), .CFG_DATA_PORT(data_port));

   line_xcvr_model line_xcvr_model_inst (.line_active(line_active), .line_bit(line_bit),
      .strap_lvl(straps), .tx_o(tx_o), .tx_oe(tx_oe), .dtr_o(dtr_o), .dtr_oe(dtr_oe),
      .rts_o(rts_o), .rts_oe(rts_oe), .wdt_o(wdt_o), .wdt_oe(wdt_oe), .serial_in(serial_in),
      .ir_in(ir_in), .tx_pin(tx_pin), .dtr_pin(dtr_pin), .rts_pin(rts_pin), .wdt_pin(wdt_pin));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      if (err_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic strap_case(input logic [3:0] s);
      logic [31:0] ec;
      ec = s[1] ? 32'h0103F803 : (s[2] ? 32'h0103E003 : 32'h00000000);
      @(posedge ref_clk);
      straps <= s;
      srst <= 1'h1;
      repeat (11) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("tx in reset", 1, tx_o);
      chk("ir tx in reset", 0, ir_tx);
      chk("strap pins in reset", s, {rts_pin, dtr_pin, tx_pin, wdt_pin});
      @(posedge ref_clk);
      srst <= 1'h0;
      repeat (3) @(negedge ref_clk);
      chk("straps", s, strap_q);
      chk("chan cfg", ec, chan_cfg);
      chk("wdt cfg", s[0] ? 32'h01044200 : 32'h00000000, wdt_cfg);
      chk("cfg ports", s[3] ? 16'h2E2F : 16'h4E4F, {idx_port, data_port});
      @(posedge ref_clk);
      straps <= ~s;
      repeat (4) @(negedge ref_clk);
      chk("straps held", s, strap_q);
      chk("tx idle pin", 1, tx_pin);
   endtask

   task automatic cfg_write(input logic dev, input uart_a_pins_pkg::cfg_field_e f, input logic [7:0] d);
      @(posedge ref_clk);
      cfg_wr <= '{1'h1, dev, f, d};
      @(posedge ref_clk);
      cfg_wr <= '0;
   endtask

   task automatic sw_case;
      cfg_write(uart_a_pins_pkg::DEV_CHAN_A, uart_a_pins_pkg::FLD_ENABLE, 8'h80);
      cfg_write(uart_a_pins_pkg::DEV_CHAN_A, uart_a_pins_pkg::FLD_BASE_LO, 8'h55);
      cfg_write(uart_a_pins_pkg::DEV_CHAN_A, uart_a_pins_pkg::FLD_IRQSEL, 8'h07);
      cfg_write(uart_a_pins_pkg::DEV_WDT, uart_a_pins_pkg::FLD_ENABLE, 8'h00);
      @(negedge ref_clk);
      chk("chan cfg written", 32'h80035507, chan_cfg);
      chk("wdt cfg written", 32'h00044200, wdt_cfg);
   endtask

   task automatic modem_case(input logic m, input logic [2:0] p);
      @(posedge ref_clk);
      gpi_mode <= m;
      gpo_mode <= m;
      rts_assert <= 1'h1;
      gpo_rts <= 1'h1;
      dtr_assert <= 1'h0;
      gpo_dtr <= 1'h0;
      modem_n <= p;
      repeat (5) @(negedge ref_clk);
      chk("modem status", {m ? p : ~p}, modem_status);
      chk("send request pin", m, rts_pin);
      chk("terminal ready pin", {~m}, dtr_pin);
   endtask

   task automatic wdt_case;
      @(posedge ref_clk);
      wdt_expired <= 1'h1;
      straps <= 4'hF;
      repeat (3) @(negedge ref_clk);
      chk("watchdog pin low", 0, wdt_pin);
      @(posedge ref_clk);
      wdt_expired <= 1'h0;
      repeat (3) @(negedge ref_clk);
      chk("watchdog released", 0, wdt_oe);
      chk("watchdog pin pulled up", 1, wdt_pin);
   endtask

   task automatic rx_case(input logic ir);
      int pulses;
      pulses = 0;
      @(posedge ref_clk);
      ir_mode <= ir;
      repeat (5) @(negedge ref_clk);
      chk("rx idle", 1, rx_line);
      @(posedge ref_clk);
      line_active <= 1'h1;
      line_bit <= 1'h0;
      repeat (8) begin
         @(negedge ref_clk);
         pulses += (rx_start === 1'h1);
      end
      chk("rx start pulses", 1, pulses);
      chk("rx low", 0, rx_line);
      @(posedge ref_clk);
      line_active <= 1'h0;
      repeat (5) @(negedge ref_clk);
      chk("rx back idle", 1, rx_line);
   endtask

   task automatic tx_frame(input logic sel, input logic ir, input logic [7:0] d, input logic [15:0] div);
      int pre, step, bitlen, cnt, first, rises, stuck;
      logic [9:0] frame;
      logic prev;
      pre = sel ? uart_a_pins_pkg::PRESCALE_48 : uart_a_pins_pkg::PRESCALE_24;
      step = pre * ((div == 16'h0000) ? 1 : int'(div));
      bitlen = step * 16;
      frame = {1'h1, d, 1'h0};
      cnt = 0;
      first = -1;
      rises = 0;
      stuck = 0;
      prev = 1'h0;
      @(posedge ref_clk);
      clk_sel_48 <= sel;
      divisor <= div;
      ir_mode <= ir;
      tx_data <= d;
      tx_start <= 1'h1;
      @(posedge ref_clk);
      tx_start <= 1'h0;
      @(negedge ref_clk);
      while (tx_busy === 1'h1 && cnt < 12 * bitlen) begin
         cnt++;
         if (first < 0 && tx_o === 1'h0) first = cnt;
         if (!ir && first >= 0 && (cnt - first) % bitlen == 100 && (cnt - first) / bitlen < 10)
            chk("tx bit", frame[(cnt - first) / bitlen], tx_o);
         if (ir && tx_o !== 1'h1) stuck = 1;
         if (ir_tx === 1'h1 && prev === 1'h0) rises++;
         prev = ir_tx;
         @(negedge ref_clk);
      end
      chk("busy span", 1, cnt >= 10 * bitlen - step && cnt <= 10 * bitlen + 2);
      chk("ir pulses", ir ? 9 - $countones(d) : 0, rises);
      chk("tx high in ir", 0, stuck);
      chk("idle after frame", 2'h2, {tx_o, ir_tx});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      static logic [3:0] pats [5] = '{4'hF, 4'h4, 4'h2, 4'h9, 4'h0};
      foreach (pats[i]) strap_case(pats[i]);
      strap_case(4'hF);
      sw_case();
      strap_case(4'hF);
      modem_case(1'h0, 3'h2);
      modem_case(1'h0, 3'h5);
      modem_case(1'h1, 3'h2);
      modem_case(1'h1, 3'h5);
      wdt_case();
      rx_case(1'h0);
      rx_case(1'h1);
      tx_frame(1'h0, 1'h0, 8'hA5, 16'h0001);
      tx_frame(1'h1, 1'h0, 8'h3C, 16'h0002);
      tx_frame(1'h0, 1'h1, 8'h0F, 16'h0000);
      chk("straps after traffic", 4'hF, strap_q);
      report_and_stop();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
